// ### hw/rcp_pkg.sv
// constants and types shared by the remote command and poll block
package rcp_pkg;
    localparam logic [7:0] END_CHAR_RST = 8'h0a;
    localparam logic [3:0] TALK_SEL_RST = 4'h0;
    localparam logic [3:0] TALK_SEL_MAX = 4'hb;
    localparam logic [7:0] SRQ_MASK_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [8:0] ARG_MAX = 9'h0ff;
    localparam logic [8:0] ARG_SAT = 9'h100;
    localparam logic [8:0] ARG_SAT_LIMIT = 9'h019;
    localparam int DISP_LEN = 20;
    localparam logic [7:0] CH_X = 8'h58;
    localparam logic [7:0] CH_G = 8'h47;
    localparam logic [7:0] CH_V = 8'h56;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_Q = 8'h51;
    localparam logic [7:0] CH_QUOTE = 8'h27;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_DIGIT0 = 8'h30;
    localparam logic [7:0] CH_DIGIT9 = 8'h39;
    localparam int STB_KEY = 7;
    localparam int STB_RSV = 6;
    localparam int STB_RTS = 5;
    localparam int STB_EXEC = 4;
    localparam int STB_BATT = 3;
    localparam int STB_FUSE = 2;
    localparam int STB_PROT = 1;
    localparam int STB_ERR = 0;
    localparam logic [7:0] RSV_MASK = 8'h40;
    typedef enum logic [1:0] {
        RCP_PS_IDLE = 2'b00,
        RCP_PS_GOTX = 2'b01,
        RCP_PS_ARG = 2'b10,
        RCP_PS_QUOTE = 2'b11
    } rcp_pstate_t;
    typedef enum logic [1:0] {
        RCP_CMD_G = 2'b00,
        RCP_CMD_V = 2'b01,
        RCP_CMD_T = 2'b10,
        RCP_CMD_Q = 2'b11
    } rcp_cmd_t;
    typedef enum logic [1:0] {
        RCP_TS_IDLE = 2'b00,
        RCP_TS_DATA = 2'b01,
        RCP_TS_END = 2'b10,
        RCP_TS_DONE = 2'b11
    } rcp_tstate_t;
    typedef enum logic [0:0] {
        RCP_GET_MODE0 = 1'b0,
        RCP_GET_MODE_NONE = 1'b1
    } rcp_get_mode_t;
endpackage

// ### hw/rcp_status.sv
// serial poll status byte with sticky conditions and service request
`timescale 1ns/1ps
`default_nettype none
module rcp_status
    import rcp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] ev_raw,
    input wire logic prog_err,
    input wire logic [7:0] srq_mask,
    input wire logic spoll_read,
    output logic [7:0] status_r,
    output logic srq_r
);
    logic [5:0] s1_r;
    logic [5:0] s2_r;
    logic [5:0] s3_r;
    logic [5:0] rise;
    logic [7:0] set_vec;
    logic [7:0] cond_now;
    logic [7:0] cond_nxt;
    logic [7:0] status_nxt;
    logic srq_nxt;

    // event pins are asynchronous: two flops, then an edge against a third
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                end
                else
                begin
                    s1_r[gi] <= ev_raw[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                end
            end
            assign rise[gi] = s2_r[gi] & ~s3_r[gi];
        end
    endgenerate

    assign set_vec = {rise[5], 1'b0, rise[4:0], prog_err};
    assign cond_now = status_r & ~RSV_MASK;
    // a new event in the read cycle survives the clear
    assign cond_nxt = spoll_read ? set_vec : (cond_now | set_vec);
    assign status_nxt = {cond_nxt[7], |cond_nxt, cond_nxt[5:0]};
    // rsv weight is masked off so it can never request service on its own
    assign srq_nxt = |(cond_nxt & srq_mask & ~RSV_MASK);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_r <= STATUS_RST;
            srq_r <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            srq_r <= srq_nxt;
        end
    end

    rsv_summary_a: assert property (@(posedge clk) disable iff (rst)
        status_r[STB_RSV] == (|(status_r & ~RSV_MASK)))
        else $error("rsv bit does not summarise the other bits");
    srq_masked_a: assert property (@(posedge clk) disable iff (rst)
        srq_r |-> |(status_r & $past(srq_mask) & ~RSV_MASK))
        else $error("srq raised without a masked condition");
    sticky_hold_a: assert property (@(posedge clk) disable iff (rst)
        status_r[STB_ERR] && !spoll_read |=> status_r[STB_ERR])
        else $error("condition bit dropped before status read");
    read_clear_a: assert property (@(posedge clk) disable iff (rst)
        spoll_read && !prog_err && rise == 6'h00 |=> status_r == STATUS_RST && !srq_r)
        else $error("status read did not clear byte and srq");
endmodule // rcp_status
`default_nettype wire

// ### hw/rcp_top.sv
// remote command interpreter, talk path and serial poll for the instrument
`timescale 1ns/1ps
`default_nettype none
module rcp_top
    import rcp_pkg::*;
#(
    parameter int DISP_CHARS = rcp_pkg::DISP_LEN
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic get_evt,
    input wire logic continuous_mode,
    input wire logic talk_addr,
    input wire logic resp_valid,
    input wire logic [7:0] resp_data,
    input wire logic resp_last,
    input wire logic tx_take,
    input wire logic [5:0] ev_raw,
    input wire logic spoll_read,
    output logic load_wave_r,
    output logic trig_pulse_r,
    output logic disp_upd_r,
    output logic [8*DISP_CHARS-1:0] disp_text_r,
    output logic [7:0] end_of_string_char_r,
    output logic [3:0] talk_content_select_r,
    output logic [7:0] service_request_mask_r,
    output logic cmd_err_r,
    output logic resp_take_r,
    output logic tx_valid_r,
    output logic [7:0] tx_data_r,
    output logic tx_eoi_n_r,
    output logic [7:0] service_status_byte,
    output logic srq_r
);
    rcp_pstate_t pst_r;
    rcp_pstate_t pst_nxt;
    rcp_cmd_t cmd_r;
    rcp_cmd_t cmd_nxt;
    rcp_tstate_t tst_r;
    rcp_get_mode_t get_mode_r;
    logic [8:0] acc_r;
    logic [8:0] acc_nxt;
    logic [4:0] cnt_r;
    logic [7:0] disp_buf [DISP_CHARS];
    logic apply;
    logic disp_show;
    logic quote_open;
    logic buf_wr;
    logic is_end_char;
    logic is_digit;
    logic is_x;
    logic is_quote;
    logic is_cmd;
    rcp_cmd_t cmd_code;
    logic [8:0] acc_step;
    logic arg_ok_g;
    logic arg_ok_v;
    logic arg_ok_t;
    logic arg_ok_q;
    logic arg_ok;
    logic can_load;

    assign is_end_char = rx_data == end_of_string_char_r;
    assign is_digit = rx_data >= CH_DIGIT0 && rx_data <= CH_DIGIT9;
    assign is_x = rx_data == CH_X;
    assign is_quote = rx_data == CH_QUOTE;
    assign is_cmd = rx_data == CH_G || rx_data == CH_V || rx_data == CH_T || rx_data == CH_Q;
    assign cmd_code = rx_data == CH_G ? RCP_CMD_G : rx_data == CH_V ? RCP_CMD_V :
                      rx_data == CH_T ? RCP_CMD_T : RCP_CMD_Q;
    // saturate so an overlong number cannot wrap into a legal value
    assign acc_step = acc_r > ARG_SAT_LIMIT ? ARG_SAT :
                      9'((acc_r << 3) + (acc_r << 1) + {5'h00, rx_data[3:0]});
    assign arg_ok_g = acc_r == 9'h000;
    assign arg_ok_v = acc_r != 9'h000 && acc_r <= ARG_MAX;
    assign arg_ok_t = acc_r <= {5'h00, TALK_SEL_MAX};
    assign arg_ok_q = acc_r <= ARG_MAX;
    assign arg_ok = cmd_r == RCP_CMD_G ? arg_ok_g : cmd_r == RCP_CMD_V ? arg_ok_v :
                    cmd_r == RCP_CMD_T ? arg_ok_t : arg_ok_q;

    always_comb
    begin
        pst_nxt = pst_r;
        cmd_nxt = cmd_r;
        acc_nxt = acc_r;
        apply = 1'b0;
        disp_show = 1'b0;
        quote_open = 1'b0;
        buf_wr = 1'b0;
        if (rx_valid)
        begin
            if (is_end_char)
            begin
                // the end char wins in every state, quoted text included
                apply = pst_r == RCP_PS_ARG;
                disp_show = pst_r == RCP_PS_QUOTE;
                pst_nxt = RCP_PS_IDLE;
            end
            else
            begin
                unique case (pst_r)
                    RCP_PS_IDLE:
                    begin
                        if (is_x)
                            pst_nxt = RCP_PS_GOTX;
                        else if (is_quote)
                        begin
                            pst_nxt = RCP_PS_QUOTE;
                            quote_open = 1'b1;
                        end
                    end
                    RCP_PS_GOTX:
                    begin
                        pst_nxt = is_cmd ? RCP_PS_ARG : RCP_PS_IDLE;
                        cmd_nxt = cmd_code;
                        acc_nxt = 9'h000;
                    end
                    RCP_PS_ARG:
                    begin
                        if (is_digit)
                            acc_nxt = acc_step;
                        else
                        begin
                            apply = 1'b1;
                            pst_nxt = is_x ? RCP_PS_GOTX : is_quote ? RCP_PS_QUOTE : RCP_PS_IDLE;
                            quote_open = is_quote;
                        end
                    end
                    RCP_PS_QUOTE:
                    begin
                        if (is_quote)
                        begin
                            disp_show = 1'b1;
                            pst_nxt = RCP_PS_IDLE;
                        end
                        else
                            buf_wr = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pst_r <= RCP_PS_IDLE;
            cmd_r <= RCP_CMD_G;
            acc_r <= 9'h000;
            get_mode_r <= RCP_GET_MODE0;
            end_of_string_char_r <= END_CHAR_RST;
            talk_content_select_r <= TALK_SEL_RST;
            service_request_mask_r <= SRQ_MASK_RST;
            cmd_err_r <= 1'b0;
        end
        else
        begin
            pst_r <= pst_nxt;
            cmd_r <= cmd_nxt;
            acc_r <= acc_nxt;
            cmd_err_r <= apply && !arg_ok;
            if (apply && arg_ok && cmd_r == RCP_CMD_V)
                end_of_string_char_r <= acc_r[7:0];
            if (apply && arg_ok && cmd_r == RCP_CMD_T)
                talk_content_select_r <= acc_r[3:0];
            if (apply && arg_ok && cmd_r == RCP_CMD_Q)
                service_request_mask_r <= acc_r[7:0];
        end
    end

    // display buffer starts blank, so unfilled positions stay padded
    genvar gi;
    generate
        for (gi = 0; gi < DISP_CHARS; gi++)
        begin : g_disp
            always_ff @(posedge clk)
            begin
                if (rst || quote_open)
                    disp_buf[gi] <= CH_SPACE;
                else if (buf_wr && cnt_r == 5'(gi))
                    disp_buf[gi] <= rx_data;
                if (rst)
                    disp_text_r[8*gi +: 8] <= CH_SPACE;
                else if (disp_show)
                    disp_text_r[8*gi +: 8] <= disp_buf[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst || quote_open)
            cnt_r <= 5'h00;
        else if (buf_wr && cnt_r < 5'(DISP_CHARS))
            cnt_r <= cnt_r + 5'h01;
        disp_upd_r <= !rst && disp_show;
    end

    // trigger path takes no part in argument checking
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            load_wave_r <= 1'b0;
            trig_pulse_r <= 1'b0;
        end
        else
        begin
            load_wave_r <= get_evt && get_mode_r == RCP_GET_MODE0;
            trig_pulse_r <= load_wave_r && !continuous_mode;
        end
    end

    // the bus side only reads tx_* while addressed; parallel poll has no path here
    assign can_load = !tx_valid_r && talk_addr;

    always_ff @(posedge clk)
    begin
        if (rst || !talk_addr)
        begin
            tst_r <= RCP_TS_IDLE;
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
            tx_eoi_n_r <= 1'b1;
            resp_take_r <= 1'b0;
        end
        else
        begin
            resp_take_r <= 1'b0;
            if (tx_take)
            begin
                tx_valid_r <= 1'b0;
                tx_eoi_n_r <= 1'b1;
            end
            unique case (tst_r)
                RCP_TS_IDLE:
                    tst_r <= RCP_TS_DATA;
                RCP_TS_DATA:
                begin
                    if (can_load && resp_valid)
                    begin
                        tx_valid_r <= 1'b1;
                        tx_data_r <= resp_data;
                        resp_take_r <= 1'b1;
                        if (resp_last)
                            tst_r <= RCP_TS_END;
                    end
                end
                RCP_TS_END:
                begin
                    if (can_load)
                    begin
                        tx_valid_r <= 1'b1;
                        tx_data_r <= end_of_string_char_r;
                        tx_eoi_n_r <= 1'b0;
                        tst_r <= RCP_TS_DONE;
                    end
                end
                RCP_TS_DONE:
                    tst_r <= RCP_TS_DONE;
            endcase
        end
    end

    rcp_status u_status (
        .clk(clk),
        .rst(rst),
        .ev_raw(ev_raw),
        .prog_err(cmd_err_r),
        .srq_mask(service_request_mask_r),
        .spoll_read(spoll_read),
        .status_r(service_status_byte),
        .srq_r(srq_r)
    );

    get_mode_zero_a: assert property (@(posedge clk) disable iff (rst)
        apply && cmd_r == RCP_CMD_G && acc_r != 9'h000 |=> cmd_err_r && get_mode_r == RCP_GET_MODE0)
        else $error("nonzero trigger-action mode not refused");
    get_then_trig_a: assert property (@(posedge clk) disable iff (rst)
        get_evt ##1 !continuous_mode |-> load_wave_r ##1 trig_pulse_r)
        else $error("trigger did not follow load");
    trig_after_load_a: assert property (@(posedge clk) disable iff (rst)
        trig_pulse_r |-> $past(load_wave_r) && !$past(continuous_mode))
        else $error("trigger pulse without preceding load");
    end_char_nul_a: assert property (@(posedge clk) disable iff (rst)
        end_of_string_char_r != 8'h00)
        else $error("end char became NUL");
    end_char_eoi_a: assert property (@(posedge clk) disable iff (rst)
        tx_valid_r && !tx_eoi_n_r |-> tx_data_r == end_of_string_char_r && tst_r == RCP_TS_DONE)
        else $error("EOI not on the end char");
    quote_term_a: assert property (@(posedge clk) disable iff (rst)
        rx_valid && is_end_char && pst_r == RCP_PS_QUOTE |=> disp_upd_r && pst_r == RCP_PS_IDLE)
        else $error("end char did not close quoted text");
    talk_gate_a: assert property (@(posedge clk) disable iff (rst)
        $rose(tx_valid_r) |-> $past(talk_addr))
        else $error("data offered while not addressed");
    talk_sel_range_a: assert property (@(posedge clk) disable iff (rst)
        talk_content_select_r <= TALK_SEL_MAX)
        else $error("talk select out of range");
endmodule // rcp_top
`default_nettype wire

// ### bench/rcp_ctl_model.sv
// controller-side talk acceptor: takes each talk byte, stalling when slow
`timescale 1ns/1ps
`default_nettype none
module rcp_ctl_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic tx_valid_r,
    input wire logic [7:0] tx_data_r,
    input wire logic tx_eoi_n_r,
    output logic tx_take
);
    logic [1:0] wait_r;
    logic [8:0] got_q[$];
    // a stalled take keeps the device holding its byte for several cycles
    always @(posedge clk)
    begin
        if (rst)
        begin
            tx_take <= 1'b0;
            wait_r <= 2'h0;
        end
        else if (tx_valid_r && !tx_take && (!slow || wait_r == 2'h3))
        begin
            tx_take <= 1'b1;
            wait_r <= 2'h0;
            got_q.push_back({tx_eoi_n_r, tx_data_r});
        end
        else
        begin
            tx_take <= 1'b0;
            wait_r <= (tx_valid_r && !tx_take) ? wait_r + 2'h1 : 2'h0;
        end
    end
endmodule // rcp_ctl_model
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the remote command and poll block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rcp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic get_evt = 1'b0;
    logic continuous_mode = 1'b0;
    logic talk_addr = 1'b0;
    logic talk_d = 1'b0;
    logic resp_valid = 1'b0;
    logic [7:0] resp_data = 8'h00;
    logic resp_last = 1'b0;
    logic [5:0] ev_raw = 6'h00;
    logic spoll_read = 1'b0;
    logic tx_take;
    logic load_wave_r, trig_pulse_r, disp_upd_r, cmd_err_r, resp_take_r, tx_valid_r, tx_eoi_n_r, srq_r;
    logic [159:0] disp_text_r;
    logic [7:0] end_of_string_char_r, service_request_mask_r, tx_data_r, service_status_byte;
    logic [3:0] talk_content_select_r;
    int err_count = 0;
    int checked = 0;
    int n_err = 0;
    int n_upd = 0;
    int n_load = 0;
    int n_trig = 0;
    time t_load = 0;
    time t_trig = 0;
    logic [7:0] end_ch = 8'h0a;
    logic [7:0] wt [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80};

    rcp_top dut (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .get_evt(get_evt),
        .continuous_mode(continuous_mode), .talk_addr(talk_addr), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_last(resp_last), .tx_take(tx_take), .ev_raw(ev_raw),
        .spoll_read(spoll_read), .load_wave_r(load_wave_r), .trig_pulse_r(trig_pulse_r),
        .disp_upd_r(disp_upd_r), .disp_text_r(disp_text_r), .end_of_string_char_r(end_of_string_char_r),
        .talk_content_select_r(talk_content_select_r), .service_request_mask_r(service_request_mask_r),
        .cmd_err_r(cmd_err_r), .resp_take_r(resp_take_r), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r),
        .tx_eoi_n_r(tx_eoi_n_r), .service_status_byte(service_status_byte), .srq_r(srq_r));
    rcp_ctl_model ctl (.clk(clk), .rst(rst), .slow(1'b1), .tx_valid_r(tx_valid_r), .tx_data_r(tx_data_r),
        .tx_eoi_n_r(tx_eoi_n_r), .tx_take(tx_take));

    always #25 clk = ~clk;

    // pulses are counted here so checks need not hit the exact cycle
    always @(posedge clk)
    begin
        talk_d <= talk_addr;
        if (cmd_err_r === 1'b1)
            n_err++;
        if (disp_upd_r === 1'b1)
            n_upd++;
        if (load_wave_r === 1'b1)
            t_load = $time;
        if (load_wave_r === 1'b1)
            n_load++;
        if (trig_pulse_r === 1'b1)
            t_trig = $time;
        if (trig_pulse_r === 1'b1)
            n_trig++;
        if (!rst && !talk_addr && !talk_d && tx_valid_r !== 1'b0)
        begin
            err_count++;
            $display("BAD %0t talk byte while not addressed", $time);
        end
    end

    task end_sim;
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [159:0] got, input logic [159:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic [159:0] dexp(input string s);
        logic [159:0] r;
        for (int i = 0; i < DISP_LEN; i++)
            r[8*i+:8] = (i < s.len()) ? s[i] : 8'h20;
        return r;
    endfunction

    // bytes go back to back; the terminator is the current end char
    task send(input string s, input bit term);
        for (int i = 0; i < s.len() + int'(term); i++)
        begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= (i < s.len()) ? s[i] : end_ch;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        tick(2);
    endtask

    task poll_clear;
        @(posedge clk);
        spoll_read <= 1'b1;
        @(posedge clk);
        spoll_read <= 1'b0;
        tick(2);
        chk(service_status_byte, 8'h00, "status after read");
        chk(srq_r, 1'b0, "srq after read");
    endtask

    // level dropped before the check so only the sticky bit can hold it
    task raise(input int b);
        @(posedge clk);
        ev_raw[b] <= 1'b1;
        repeat (2) @(posedge clk);
        ev_raw[b] <= 1'b0;
        tick(5);
    endtask

    task get(input logic cont);
        int nl;
        int nt;
        nl = n_load;
        nt = n_trig;
        @(posedge clk);
        continuous_mode <= cont;
        get_evt <= 1'b1;
        @(posedge clk);
        get_evt <= 1'b0;
        tick(4);
        chk(n_load - nl, 1, "load count");
        chk(n_trig - nt, !cont, "trigger count");
        if (!cont)
            chk(t_trig - t_load, 50, "trigger after load");
    endtask

    task wait_take;
        int k;
        k = 0;
        @(posedge clk);
        while (resp_take_r !== 1'b1 && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        chk(resp_take_r, 1'b1, "response byte taken");
    endtask

    initial
    begin
        #400000;
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        end_sim;
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk(end_of_string_char_r, 8'h0a, "end char at reset");
        chk(talk_content_select_r, 4'h0, "talk select at reset");
        chk(service_status_byte, 8'h00, "status at reset");
        chk(disp_text_r, dexp(""), "blank display at reset");
        chk(tx_eoi_n_r, 1'b1, "eoi idle");
        get(1'b0);
        get(1'b1);
        chk(n_err, 0, "trigger makes no error");
        send("XG0", 1);
        chk(n_err, 0, "mode zero accepted");
        send("XG1", 1);
        chk(n_err, 1, "mode one refused");
        chk(service_status_byte, 8'h41, "error bit with rsv");
        chk(srq_r, 1'b0, "srq masked off");
        poll_clear;
        send("XQ255", 1);
        chk(service_request_mask_r, 8'hff, "mask 255");
        for (int i = 0; i < 6; i++)
        begin
            raise(i);
            chk(service_status_byte, wt[i] | 8'h40, "event weight");
            chk(srq_r, 1'b1, "srq enabled");
            poll_clear;
        end
        send("XQ64", 1);
        chk(service_request_mask_r, 8'h40, "mask 64");
        raise(0);
        chk(service_status_byte, 8'h42, "protection with rsv");
        chk(srq_r, 1'b0, "rsv mask bit enables nothing");
        poll_clear;
        send("XQ2", 1);
        raise(0);
        chk(srq_r, 1'b1, "protection srq");
        poll_clear;
        send("XV0", 1);
        chk(n_err, 2, "nul terminator refused");
        chk(end_of_string_char_r, 8'h0a, "terminator kept");
        send("XV13", 1);
        end_ch = 8'h0d;
        chk(end_of_string_char_r, 8'h0d, "terminator cr");
        send("'A", 1);
        chk(n_upd, 1, "text closed by end char");
        chk(disp_text_r, dexp("A"), "short text padded");
        send("'abcdefghijklmnopqrstuv'", 0);
        chk(n_upd, 2, "text closed by quote");
        chk(disp_text_r, dexp("abcdefghijklmnopqrst"), "first 20 shown");
        send("XT3", 1);
        chk(talk_content_select_r, 4'h3, "talk select 3");
        send("XT12", 1);
        chk(talk_content_select_r, 4'h3, "select 12 refused");
        poll_clear;
        @(posedge clk);
        talk_addr <= 1'b1;
        resp_valid <= 1'b1;
        resp_data <= 8'h48;
        wait_take;
        resp_data <= 8'h49;
        resp_last <= 1'b1;
        wait_take;
        resp_valid <= 1'b0;
        resp_last <= 1'b0;
        for (int k = 0; k < 100 && ctl.got_q.size() < 3; k++)
            @(posedge clk);
        tick(4);
        chk(ctl.got_q.size(), 3, "talk byte count");
        chk(ctl.got_q[0], 9'h148, "first talk byte");
        chk(ctl.got_q[1], 9'h149, "second talk byte");
        chk(ctl.got_q[2], 9'h00d, "end char with eoi");
        @(posedge clk);
        talk_addr <= 1'b0;
        tick(4);
        // a reset in mid-run must bring back every power-up setting
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk(end_of_string_char_r, 8'h0a, "end char after reset");
        chk(talk_content_select_r, 4'h0, "talk select after reset");
        chk(service_request_mask_r, 8'h00, "mask after reset");
        end_ch = 8'h0a;
        get(1'b0);
        end_sim;
    end
endmodule // tb_top
`default_nettype wire
